// ===== flash_dev_end.sv
// Purpose: device end of the flash pin link: pin roles, pause, reset, lanes
// Assumes: all link pins are asynchronous to core_clk and are synchronised
// Notes: byte stream only; command decoding lives elsewhere
`timescale 1ns/1ps
module flash_dev_end #(
	parameter bit HAS_DEDICATED_RESET = 1'b0 // separate reset pin fitted
) (
	input wire logic core_clk, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic clk_en, // freezes all state when low
	flash_link_if.device link, // pins to the controller
	input wire logic [7:0] status_reg, // status register contents
	input wire logic reset_pin_select_bit, // shared pin role
	input wire flash_pin_pkg::link_width_t link_width, // requested lane mode
	input wire logic four_line_command_mode, // four-line command mode
	input wire logic dev_drive, // device drives in this phase
	input wire logic [7:0] tx_data, // next byte to send
	output logic tx_load, // tx_data taken
	output logic [7:0] rx_data, // last byte received
	output logic rx_valid, // rx_data new
	output logic selected, // chip select seen low
	output logic paused, // hold in force
	output logic in_reset, // reset pin low
	output logic clock_mode_3, // idle clock was high
	input wire logic [flash_pin_pkg::ADDR_W-1:0] addr, // byte address to map
	output logic [flash_pin_pkg::ADDR_W-flash_pin_pkg::SECTOR_SHIFT-1:0] sector_index, // 4K sector
	output logic [flash_pin_pkg::ADDR_W-flash_pin_pkg::BLK32_SHIFT-1:0] block32_index, // 32K block
	output logic [flash_pin_pkg::ADDR_W-flash_pin_pkg::BLK64_SHIFT-1:0] block64_index // 64K block
);
	import flash_pin_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [6:0] pin_raw;
	logic [6:0] pin_meta;
	logic [6:0] pin_sync;
	logic sclk_q;
	logic cs_q;

	// bit 6 reset, 5 select, 4 clock, 3..0 data lines
	assign pin_raw = {link.hw_reset_n, link.chip_sel_n, link.sclk, link.line};

	// two stages before any logic looks at a pin
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			pin_meta <= PIN_IDLE;
			pin_sync <= PIN_IDLE;
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
		end
		else if (clk_en)
		begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			sclk_q <= pin_sync[4];
			cs_q <= pin_sync[5];
		end
	end

	// ----------------------------------------------------------------
	// pin roles
	// ----------------------------------------------------------------
	logic quad_en;
	link_width_t width;
	logic hold_role;
	logic shared_reset_role;
	logic reset_low;
	logic cs_low;
	logic pause;
	logic armed;
	logic go;
	logic rise;
	logic fall;
	logic cs_fall;
	logic [3:0] drive_mask;

	assign quad_en = status_reg[QUAD_EN_POS];
	assign width = eff_width(link_width, four_line_command_mode, quad_en);
	// with quad enabled the shared pin is data line 3 whatever the select bit says
	assign hold_role = !quad_en && (HAS_DEDICATED_RESET || reset_pin_select_bit == SEL_PAUSE);
	assign shared_reset_role = !quad_en && !HAS_DEDICATED_RESET && reset_pin_select_bit == SEL_RESET;
	assign reset_low = HAS_DEDICATED_RESET ? !pin_sync[6] : (shared_reset_role && !pin_sync[3]);
	assign cs_low = !pin_sync[5];
	assign pause = hold_role && !pin_sync[3] && cs_low;
	// nothing is taken until select has been seen high since reset
	assign go = armed && cs_low && !pause && !reset_low;
	assign rise = pin_sync[4] && !sclk_q;
	assign fall = !pin_sync[4] && sclk_q;
	assign cs_fall = cs_q && cs_low;

	// ----------------------------------------------------------------
	// lane output enables
	// ----------------------------------------------------------------
	// single mode drives only the serial output line
	always_comb
	begin
		case (width)
			LINK_QUAD: drive_mask = MASK_QUAD;
			LINK_DUAL: drive_mask = MASK_DUAL;
			default: drive_mask = MASK_SO;
		endcase
	end

	// ----------------------------------------------------------------
	// shift engine
	// ----------------------------------------------------------------
	logic [3:0] pos;
	logic [7:0] rx_sh;
	logic [7:0] tx_sh;
	logic [3:0] dout;
	logic drive_q;
	logic [3:0] next_pos;
	logic [7:0] next_rx_sh;
	logic [7:0] next_tx_sh;
	logic [3:0] next_dout;
	logic next_drive;
	logic next_armed;
	logic [7:0] next_rx_data;
	logic next_rx_valid;
	logic next_tx_load;
	logic next_mode3;
	logic [3:0] step_pos;

	// a pause simply blocks every edge, so position and shifters hold still
	always_comb
	begin
		next_pos = pos;
		next_rx_sh = rx_sh;
		next_tx_sh = tx_sh;
		next_dout = dout;
		next_drive = drive_q;
		next_armed = armed;
		next_rx_data = rx_data;
		next_rx_valid = 1'b0;
		next_tx_load = 1'b0;
		next_mode3 = clock_mode_3;
		step_pos = pos + lane_step(width);
		if (reset_low)
		begin
			next_pos = 4'h0;
			next_rx_sh = 8'h00;
			next_dout = 4'h0;
			next_drive = 1'b0;
		end
		else if (!cs_low)
		begin
			// deselected: data ignored, sequence restarts
			next_armed = 1'b1;
			next_pos = 4'h0;
			next_drive = 1'b0;
			next_tx_sh = tx_data;
		end
		else
		begin
			if (cs_fall)
				next_mode3 = pin_sync[4];
			// mode 0 has no fall before the first rise, so select falling launches the top bits
			if (go && cs_fall)
			begin
				next_dout = lane_out(tx_sh, width, 1'b1);
				next_drive = dev_drive;
			end
			if (go && rise)
			begin
				next_rx_sh = lane_in(rx_sh, pin_sync[3:0], width, 1'b0);
				next_tx_sh = tx_sh << lane_step(width);
				next_pos = step_pos;
				if (step_pos >= BYTE_BITS)
				begin
					next_rx_data = lane_in(rx_sh, pin_sync[3:0], width, 1'b0);
					next_rx_valid = 1'b1;
					next_tx_sh = tx_data;
					next_tx_load = 1'b1;
					next_pos = 4'h0;
				end
			end
			if (go && fall)
			begin
				next_dout = lane_out(tx_sh, width, 1'b1);
				next_drive = dev_drive;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			pos <= 4'h0;
			rx_sh <= 8'h00;
			tx_sh <= 8'h00;
			dout <= 4'h0;
			drive_q <= 1'b0;
			armed <= 1'b0;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
			tx_load <= 1'b0;
			clock_mode_3 <= 1'b0;
			selected <= 1'b0;
			paused <= 1'b0;
			in_reset <= 1'b0;
		end
		else if (clk_en)
		begin
			pos <= next_pos;
			rx_sh <= next_rx_sh;
			tx_sh <= next_tx_sh;
			dout <= next_dout;
			drive_q <= next_drive;
			armed <= next_armed;
			rx_data <= next_rx_data;
			rx_valid <= next_rx_valid;
			tx_load <= next_tx_load;
			clock_mode_3 <= next_mode3;
			selected <= armed && cs_low;
			paused <= pause;
			in_reset <= reset_low;
		end
	end

	// released while paused, in reset or deselected
	assign link.dev_out = dout;
	assign link.dev_oe_n = ~(drive_mask & {4{drive_q && go}});

	// ----------------------------------------------------------------
	// array map
	// ----------------------------------------------------------------
	// uniform sectors, blocks of adjacent sectors
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			sector_index <= '0;
			block32_index <= '0;
			block64_index <= '0;
		end
		else if (clk_en)
		begin
			sector_index <= addr[ADDR_W-1:SECTOR_SHIFT];
			block32_index <= addr[ADDR_W-1:BLK32_SHIFT];
			block64_index <= addr[ADDR_W-1:BLK64_SHIFT];
		end
	end
endmodule : flash_dev_end

// ===== flash_host_end.sv
// Purpose: controller end of the flash pin link: clock, select, lanes
// Assumes: device data returns within one link clock period
// Notes: link clock is divided from core_clk; one byte per start
`timescale 1ns/1ps
module flash_host_end #(
	parameter bit HAS_DEDICATED_RESET = 1'b0, // separate reset pin fitted
	parameter int HALF_CYCLES = flash_pin_pkg::HOST_HALF_CYCLES // core cycles per clock half
) (
	input wire logic core_clk, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic clk_en, // freezes all state when low
	flash_link_if.host link, // pins to the device
	input wire logic select, // hold chip select low
	input wire logic start, // start one byte
	input wire logic [7:0] tx_data, // byte to send
	input wire logic host_send, // host drives data lanes
	input wire logic clock_mode_3, // idle clock high
	input wire logic quad_enable_bit, // copy of device bit
	input wire logic reset_pin_select_bit, // copy of device bit
	input wire flash_pin_pkg::link_width_t link_width, // requested lane mode
	input wire logic four_line_command_mode, // four-line command mode
	input wire logic pause_req, // pull hold low
	input wire logic reset_req, // pull reset low
	output logic busy, // byte in flight
	output logic done, // byte finished
	output logic [7:0] rx_data // byte sampled
);
	import flash_pin_pkg::*;

	if (HALF_CYCLES < MIN_HALF_CYCLES || HALF_CYCLES > 255)
		$error("HALF_CYCLES out of range");

	localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

	typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} host_state_t;

	// ----------------------------------------------------------------
	// roles and enables
	// ----------------------------------------------------------------
	logic [3:0] line_meta;
	logic [3:0] line_sync;
	link_width_t width;
	logic hold_role;
	logic holding;
	logic shared_reset;
	logic [3:0] drv;

	assign width = eff_width(link_width, four_line_command_mode, quad_enable_bit);
	assign hold_role = !quad_enable_bit && (HAS_DEDICATED_RESET || reset_pin_select_bit == SEL_PAUSE);
	assign shared_reset = !quad_enable_bit && !HAS_DEDICATED_RESET && reset_pin_select_bit == SEL_RESET;
	assign holding = pause_req && hold_role;

	// outside quad the control pins stay driven; single always drives line 0
	always_comb
	begin
		case (width)
			LINK_QUAD: drv = host_send ? MASK_QUAD : 4'h0;
			LINK_DUAL: drv = (host_send ? MASK_DUAL : 4'h0) | MASK_CTRL;
			default: drv = MASK_SI | MASK_CTRL;
		endcase
	end
	assign link.host_oe_n = ~drv;

	// ----------------------------------------------------------------
	// clock and shift sequencer
	// ----------------------------------------------------------------
	host_state_t state;
	host_state_t next_state;
	logic [7:0] timer;
	logic [7:0] next_timer;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [3:0] step_cnt;
	logic [7:0] tx_sh;
	logic [7:0] next_tx_sh;
	logic [7:0] rx_sh;
	logic [7:0] next_rx_sh;
	logic [7:0] next_rx_data;
	logic next_done;
	logic sclk_r;
	logic next_sclk;
	logic [3:0] hout;
	logic [3:0] next_hout;

	always_comb
	begin
		next_state = state;
		next_timer = timer;
		next_cnt = cnt;
		next_tx_sh = tx_sh;
		next_rx_sh = rx_sh;
		next_rx_data = rx_data;
		next_done = 1'b0;
		next_sclk = sclk_r;
		step_cnt = cnt + lane_step(width);
		case (state)
			H_IDLE:
			begin
				next_sclk = clock_mode_3;
				if (start && select && !holding && !reset_req)
				begin
					next_state = H_LOW;
					next_tx_sh = tx_data;
					next_cnt = 4'h0;
					next_timer = 8'h00;
					next_sclk = 1'b0;
				end
			end
			H_LOW:
			begin
				// a held pause freezes the clock where it stands
				if (!holding && timer == HALF_LAST)
				begin
					next_timer = 8'h00;
					next_sclk = 1'b1;
					next_state = H_HIGH;
				end
				else if (!holding)
					next_timer = timer + 8'h01;
			end
			H_HIGH:
			begin
				if (!holding && timer == HALF_LAST)
				begin
					// sample just before the fall, when the device data has settled
					next_rx_sh = lane_in(rx_sh, line_sync, width, 1'b1);
					next_tx_sh = tx_sh << lane_step(width);
					next_cnt = step_cnt;
					next_timer = 8'h00;
					if (step_cnt >= BYTE_BITS)
					begin
						next_rx_data = lane_in(rx_sh, line_sync, width, 1'b1);
						next_done = 1'b1;
						next_state = H_IDLE;
						next_sclk = clock_mode_3;
					end
					else
					begin
						next_state = H_LOW;
						next_sclk = 1'b0;
					end
				end
				else if (!holding)
					next_timer = timer + 8'h01;
			end
			default:
				next_state = H_IDLE;
		endcase
		if (!select)
			next_state = H_IDLE;
		next_hout = lane_out(next_tx_sh, width, 1'b0);
		if (width != LINK_QUAD)
		begin
			next_hout[2] = 1'b1;
			next_hout[3] = !(holding || (reset_req && shared_reset));
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			line_meta <= LINE_IDLE;
			line_sync <= LINE_IDLE;
			state <= H_IDLE;
			timer <= 8'h00;
			cnt <= 4'h0;
			tx_sh <= 8'h00;
			rx_sh <= 8'h00;
			rx_data <= 8'h00;
			done <= 1'b0;
			sclk_r <= 1'b0;
			hout <= LINE_IDLE;
			link.chip_sel_n <= 1'b1;
			link.hw_reset_n <= 1'b1;
		end
		else if (clk_en)
		begin
			line_meta <= link.line;
			line_sync <= line_meta;
			state <= next_state;
			timer <= next_timer;
			cnt <= next_cnt;
			tx_sh <= next_tx_sh;
			rx_sh <= next_rx_sh;
			rx_data <= next_rx_data;
			done <= next_done;
			sclk_r <= next_sclk;
			hout <= next_hout;
			link.chip_sel_n <= !select;
			// the user keeps reset off while the device is busy writing
			link.hw_reset_n <= !(reset_req && HAS_DEDICATED_RESET);
		end
	end

	assign link.sclk = sclk_r;
	assign link.host_out = hout;
	assign busy = state != H_IDLE;
endmodule : flash_host_end

// ===== flash_link_if.sv
// Purpose: pin bundle between flash controller and flash device
// Assumes: lines are pulled up when neither end drives
// Notes: enables are active low; device wins a drive clash
`timescale 1ns/1ps
interface flash_link_if;
	logic chip_sel_n;
	logic sclk;
	logic hw_reset_n;
	logic [3:0] host_out;
	logic [3:0] host_oe_n;
	logic [3:0] dev_out;
	logic [3:0] dev_oe_n;
	logic [3:0] line;

	// resolved level of each data line
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (!dev_oe_n[i])
				line[i] = dev_out[i];
			else if (!host_oe_n[i])
				line[i] = host_out[i];
			else
				line[i] = 1'b1;
		end
	end

	modport device (input chip_sel_n, sclk, hw_reset_n, line, output dev_out, dev_oe_n);
	modport host (output chip_sel_n, sclk, hw_reset_n, host_out, host_oe_n, input line);
endinterface : flash_link_if

// ===== flash_link_props.sv
// Purpose: concurrent checks on the flash pin link between the two ends
// Assumes: link clock half period of four core cycles
// Notes: sees only interface signals; instantiated beside the interface
`timescale 1ns/1ps
module flash_link_props (
	input wire logic core_clk, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic chip_sel_n, // select pin
	input wire logic sclk, // link clock
	input wire logic [3:0] host_out, // host lane values
	input wire logic [3:0] host_oe_n, // host lane enables
	input wire logic [3:0] dev_oe_n // device lane enables
);
	// ----------------------------------------------------------------
	// link checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	oe_desel_a: assert property (chip_sel_n [*3] |-> dev_oe_n == 4'hF)
		else $error("device drives while deselected");
	oe_shape_a: assert property (dev_oe_n != 4'hF |-> dev_oe_n inside {4'hD, 4'hC, 4'h0})
		else $error("device drives an illegal lane set");
	lane_clash_a: assert property (!chip_sel_n |-> ((~dev_oe_n) & (~host_oe_n)) == 4'h0)
		else $error("both ends drive one lane");
	clk_high_a: assert property ($rose(sclk) && !chip_sel_n |-> sclk [*4])
		else $error("link clock high phase too short");
	data_setup_a: assert property ($rose(sclk) && !chip_sel_n |-> $stable(host_out[2:0]))
		else $error("host lanes move at the sampling edge");
	data_hold_a: assert property ($rose(sclk) && !chip_sel_n |=> $stable(host_out[2:0]) [*3])
		else $error("host lanes move in the high phase");
	sel_fall_a: assert property ($fell(chip_sel_n) |-> $stable(sclk))
		else $error("clock moves as select falls");
	rst_vals_a: assert property ($fell(sys_rst) |-> chip_sel_n && !sclk && host_out == 4'hF && dev_oe_n == 4'hF)
		else $error("pins not idle after reset");

	// main traffic kinds seen
	cover property ($fell(chip_sel_n) && sclk);
	cover property (dev_oe_n == 4'hC);
	cover property (dev_oe_n == 4'h0);
endmodule : flash_link_props

// ===== flash_pin_pkg.sv
// Purpose: shared constants, types and lane helpers for the flash pin link
// Assumes: both ends run on core_clk at 100 MHz
// Notes: lanes are sent most significant bit first
// Summary of operation
// - hold pin is data line 3 when quad enabled
// - paused while selected: serial output released
// - pause freezes the sequence, release resumes it
// - reset pin low: reset state, outputs released
// - controller avoids reset during internal writes; the host end passes reset_req to the reset pin unchecked
// - select bit: 0 pause, 1 reset
// - dual mode: lines 0 and 1 bidirectional
// - quad modes: lines 0 to 3 bidirectional
// - clock modes 0 and 3 only
// - device samples on rising edge, host just before falling; both drive from falling
// - 4K sectors, 32K and 64K blocks
// - chip select must fall before acceptance
// - quad enable is status bit 6
package flash_pin_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_PERIOD_NS = 80;
	localparam int HOST_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int MIN_HALF_CYCLES = 4;
	// ----------------------------------------------------------------
	// pin roles and fields
	// ----------------------------------------------------------------
	localparam int QUAD_EN_POS = 6;
	localparam logic SEL_PAUSE = 1'b0;
	localparam logic SEL_RESET = 1'b1;
	localparam logic [6:0] PIN_IDLE = 7'h6F;
	localparam logic [3:0] LINE_IDLE = 4'hF;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] MASK_QUAD = 4'hF;
	localparam logic [3:0] MASK_DUAL = 4'h3;
	localparam logic [3:0] MASK_SO = 4'h2;
	localparam logic [3:0] MASK_SI = 4'h1;
	localparam logic [3:0] MASK_CTRL = 4'hC;
	// ----------------------------------------------------------------
	// array layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 25;
	localparam int SECTOR_BYTES = 4096;
	localparam int BLK32_SECTORS = 8;
	localparam int BLK64_SECTORS = 16;
	localparam int SECTOR_SHIFT = $clog2(SECTOR_BYTES);
	localparam int BLK32_SHIFT = SECTOR_SHIFT + $clog2(BLK32_SECTORS);
	localparam int BLK64_SHIFT = SECTOR_SHIFT + $clog2(BLK64_SECTORS);

	typedef enum logic [1:0] {LINK_SINGLE, LINK_DUAL, LINK_QUAD} link_width_t;

	// quad needs the quad enable bit; otherwise fall back to single
	function automatic link_width_t eff_width(input link_width_t req, input logic four_line, input logic quad_en);
		if (quad_en && (four_line || req == LINK_QUAD))
			eff_width = LINK_QUAD;
		else if (req == LINK_DUAL)
			eff_width = LINK_DUAL;
		else
			eff_width = LINK_SINGLE;
	endfunction : eff_width

	function automatic logic [3:0] lane_step(input link_width_t w);
		case (w)
			LINK_QUAD: lane_step = 4'h4;
			LINK_DUAL: lane_step = 4'h2;
			default: lane_step = 4'h1;
		endcase
	endfunction : lane_step

	// top bits of a shift register onto the lines
	function automatic logic [3:0] lane_out(input logic [7:0] sh, input link_width_t w, input logic on_1);
		case (w)
			LINK_QUAD: lane_out = sh[7:4];
			LINK_DUAL: lane_out = {2'h0, sh[7:6]};
			default: lane_out = on_1 ? {2'h0, sh[7], 1'b0} : {3'h0, sh[7]};
		endcase
	endfunction : lane_out

	// shift sampled lines into the low end
	function automatic logic [7:0] lane_in(input logic [7:0] sh, input logic [3:0] ln, input link_width_t w,
		input logic from_1);
		case (w)
			LINK_QUAD: lane_in = {sh[3:0], ln};
			LINK_DUAL: lane_in = {sh[5:0], ln[1:0]};
			default: lane_in = {sh[6:0], from_1 ? ln[1] : ln[0]};
		endcase
	endfunction : lane_in
endpackage : flash_pin_pkg

// ===== flash_serial_pin_mode_logic_tb.sv
// Purpose: drives both link ends against each other and judges the bytes
// Assumes: shared hold/reset pin, link clock of 80 ns from the host divider
// Notes: direction changes only with select released, so lanes never clash
`timescale 1ns/1ps
module flash_serial_pin_mode_logic_tb;
	import flash_pin_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic select = 1'b0;
	logic start = 1'b0;
	logic host_send = 1'b0;
	logic dev_drive = 1'b0;
	logic mode3 = 1'b0;
	logic quad_en = 1'b0;
	logic rsel = 1'b0;
	logic four = 1'b0;
	logic pause_req = 1'b0;
	logic reset_req = 1'b0;
	link_width_t width = LINK_SINGLE;
	logic [7:0] h_tx = 8'h00;
	logic [7:0] d_tx = 8'h00;
	logic [24:0] addr = 25'h0000000;
	logic [7:0] h_rx, d_rx, d_got;
	logic done, busy, selected, d_load, d_rxv, paused, in_reset, d_mode3;
	logic [12:0] sec;
	logic [9:0] blk32;
	logic [8:0] blk64;
	int errors = 0;
	int comparisons = 0;
	int loads = 0;

	// ----------------------------------------------------------------
	// clock, ends and checker
	// ----------------------------------------------------------------
	always #5 core_clk = ~core_clk;

	flash_link_if u_flash_link_if ();

	flash_dev_end #(.HAS_DEDICATED_RESET(1'b0)) u_flash_dev_end (.core_clk(core_clk), .sys_rst(sys_rst),
		.clk_en(1'b1), .link(u_flash_link_if.device), .status_reg({1'b0, quad_en, 6'h00}),
		.reset_pin_select_bit(rsel), .link_width(width), .four_line_command_mode(four), .dev_drive(dev_drive),
		.tx_data(d_tx), .tx_load(d_load), .rx_data(d_rx), .rx_valid(d_rxv), .selected(selected), .paused(paused),
		.in_reset(in_reset), .clock_mode_3(d_mode3), .addr(addr), .sector_index(sec), .block32_index(blk32),
		.block64_index(blk64));

	flash_host_end #(.HAS_DEDICATED_RESET(1'b0), .HALF_CYCLES(HOST_HALF_CYCLES)) u_flash_host_end (
		.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1), .link(u_flash_link_if.host), .select(select),
		.start(start), .tx_data(h_tx), .host_send(host_send), .clock_mode_3(mode3), .quad_enable_bit(quad_en),
		.reset_pin_select_bit(rsel), .link_width(width), .four_line_command_mode(four), .pause_req(pause_req),
		.reset_req(reset_req), .busy(busy), .done(done), .rx_data(h_rx));

	flash_link_props u_flash_link_props (.core_clk(core_clk), .sys_rst(sys_rst),
		.chip_sel_n(u_flash_link_if.chip_sel_n), .sclk(u_flash_link_if.sclk), .host_out(u_flash_link_if.host_out),
		.host_oe_n(u_flash_link_if.host_oe_n), .dev_oe_n(u_flash_link_if.dev_oe_n));

	// keep the last byte the device end received
	always @(posedge core_clk)
	begin
		if (d_rxv === 1'b1)
			d_got <= d_rx;
		if (d_load === 1'b1)
			loads <= loads + 1;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task report_and_stop;
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// one byte each way; hold_at nonzero pauses mid-byte after that many cycles
	task xfer(input logic [7:0] hb, input logic [7:0] db, input logic hs, input logic dd, input int hold_at);
		int n;
		h_tx = hb;
		d_tx = db;
		host_send = hs;
		dev_drive = dd;
		repeat (4) @(negedge core_clk);
		select = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("selected", selected, 16'h1);
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		chk("busy", busy, 16'h1);
		n = 0;
		while (done !== 1'b1 && n < 400)
		begin
			@(negedge core_clk);
			n++;
			if (n == hold_at)
			begin
				pause_req = 1'b1;
				repeat (12) @(negedge core_clk);
				chk("paused", paused, 16'h1);
				chk("so_oe_n", u_flash_link_if.dev_oe_n[1], 16'h1);
				pause_req = 1'b0;
			end
		end
		if (n >= 400)
		begin
			errors++;
			report_and_stop();
		end
		repeat (6) @(negedge core_clk);
		select = 1'b0;
		// device keeps driving until it sees select high; no lane or mode change before then
		repeat (6) @(negedge core_clk);
	endtask : xfer

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task s_modes;
		for (int m = 0; m < 2; m++)
		begin
			mode3 = m[0];
			xfer(8'hA5 ^ m[7:0], 8'h3C ^ m[7:0], 1'b0, 1'b1, 0);
			chk("host_rx", h_rx, 8'h3C ^ m[7:0]);
			chk("dev_rx", d_got, 8'hA5 ^ m[7:0]);
			chk("mode3", d_mode3, m[0]);
			chk("tx_load", loads, 16'(m + 1));
		end
		mode3 = 1'b0;
	endtask : s_modes

	// dual, quad, four-line command, and quad without enable falling back
	task automatic s_widths;
		logic qv [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		link_width_t wv [4] = '{LINK_DUAL, LINK_QUAD, LINK_SINGLE, LINK_QUAD};
		logic fv [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++)
		begin
			quad_en = qv[i];
			width = wv[i];
			four = fv[i];
			xfer({4'h9, i[3:0]}, 8'h00, 1'b1, 1'b0, 0);
			chk("dev_rx", d_got, {4'h9, i[3:0]});
			xfer(8'hFF, {4'h5, i[3:0]}, 1'b0, 1'b1, 0);
			chk("host_rx", h_rx, {4'h5, i[3:0]});
		end
		quad_en = 1'b0;
		width = LINK_SINGLE;
		four = 1'b0;
	endtask : s_widths

	task s_pause;
		xfer(8'hC3, 8'h69, 1'b0, 1'b1, 20);
		chk("host_rx", h_rx, 8'h69);
		chk("dev_rx", d_got, 8'hC3);
	endtask : s_pause

	// shared pin in reset role; raised only with nothing in flight
	task s_reset;
		rsel = 1'b1;
		select = 1'b1;
		repeat (4) @(negedge core_clk);
		reset_req = 1'b1;
		repeat (6) @(negedge core_clk);
		chk("in_reset", in_reset, 16'h1);
		chk("paused", paused, 16'h0);
		chk("dev_oe_n", u_flash_link_if.dev_oe_n, 16'hF);
		reset_req = 1'b0;
		select = 1'b0;
		repeat (6) @(negedge core_clk);
		chk("in_reset", in_reset, 16'h0);
		xfer(8'h5A, 8'hE1, 1'b0, 1'b1, 0);
		chk("host_rx", h_rx, 8'hE1);
		chk("dev_rx", d_got, 8'h5A);
		rsel = 1'b0;
	endtask : s_reset

	task automatic s_map;
		logic [24:0] av [2] = '{25'h0000FFF, 25'h1FEF123};
		for (int i = 0; i < 2; i++)
		begin
			addr = av[i];
			repeat (2) @(negedge core_clk);
			chk("sector", sec, av[i][24:12]);
			chk("block32", blk32, av[i][24:15]);
			chk("block64", blk64, av[i][24:16]);
		end
	endtask : s_map

	// main sequence
	initial
	begin
		repeat (3) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge core_clk);
		s_modes();
		s_widths();
		s_pause();
		s_reset();
		s_map();
		report_and_stop();
	end
endmodule : flash_serial_pin_mode_logic_tb
